// ==== rtl/mio_pkg.sv ====
// shared constants, modes and carrier types for the module port logic
package mio_pkg;

	// per-pin operating modes
	typedef enum logic [2:0] {
		MIO_MODE_MCU_IO,
		MIO_MODE_LOGIC_OUT,
		MIO_MODE_LOGIC_IN,
		MIO_MODE_ADDR_OUT,
		MIO_MODE_PERIPH_IO
	} mio_mode_t;

	// per-port driver sources, one bit per pin
	typedef struct packed {
		logic [7:0] mcu_dir;
		logic [7:0] mcu_dout;
		logic [7:0] cell_dout;
		logic [7:0] cell_oe;
		logic [7:0] addr_dout;
		logic [7:0] periph_dout;
		logic [7:0] periph_oe;
	} mio_pin_src_t;

	// control window offsets
	localparam logic [7:0] DRV_A_OFS = 8'h08;
	localparam logic [7:0] DRV_B_OFS = 8'h09;
	localparam logic [7:0] OE_A_OFS = 8'h0C;
	localparam logic [7:0] OE_B_OFS = 8'h0D;
	localparam logic [7:0] DRV_C_OFS = 8'h16;
	localparam logic [7:0] DRV_D_OFS = 8'h17;
	localparam logic [7:0] OE_C_OFS = 8'h1A;
	localparam logic [7:0] OE_D_OFS = 8'h1B;

	// reset values and field masks
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] AB_SLEW_MASK = 8'h0F;
	localparam logic [7:0] AB_OD_MASK = 8'hF0;
	localparam logic [7:0] PC_PIN_MASK = 8'h9C;
	localparam logic [7:0] PD_PIN_MASK = 8'h06;

	// dedicated and general-purpose pin positions
	localparam int PC_BATT_BIT = 2;
	localparam int PC_RDY_BIT = 3;
	localparam int PC_STBY_BIT = 4;
	localparam int PC_GP_BIT = 7;
	localparam int PD_CLK_BIT = 1;
	localparam int PD_CSI_BIT = 2;

endpackage : mio_pkg

// ==== rtl/mio_sync.sv ====
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module mio_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// data
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_o <= '0;
		end else begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end
endmodule : mio_sync

// ==== rtl/mio_pin_cell.sv ====
// one port pin: mode mux, output-enable combine and drive type
`timescale 1ns/1ns
module mio_pin_cell #(
	parameter bit OD_OK = 1'b0,
	parameter bit SLEW_OK = 1'b0,
	parameter bit PERIPH_OK = 1'b0,
	parameter bit ADDR_OK = 1'b0
) (
	// mode
	input wire mio_pkg::mio_mode_t mode_i,
	// sources
	input wire logic mcu_dir_i,
	input wire logic mcu_dout_i,
	input wire logic cell_dout_i,
	input wire logic cell_oe_i,
	input wire logic addr_dout_i,
	input wire logic periph_dout_i,
	input wire logic periph_oe_i,
	input wire logic alt_drive_i,
	input wire logic ded_en_i,
	input wire logic ded_dout_i,
	input wire logic ded_oe_i,
	// results
	output logic dout_o,
	output logic oe_o,
	output logic pin_oe_o,
	output logic fast_o
);
	always_comb begin
		dout_o = mcu_dout_i;
		oe_o = 1'b0;
		if (ded_en_i) begin
			dout_o = ded_dout_i;
			oe_o = ded_oe_i;
		end else begin
			case (mode_i)
				mio_pkg::MIO_MODE_MCU_IO: begin
					oe_o = mcu_dir_i;
				end
				mio_pkg::MIO_MODE_LOGIC_OUT: begin
					dout_o = cell_dout_i;
					oe_o = cell_oe_i;
				end
				mio_pkg::MIO_MODE_ADDR_OUT: begin
					dout_o = addr_dout_i;
					oe_o = ADDR_OK;
				end
				mio_pkg::MIO_MODE_PERIPH_IO: begin
					// ports without peripheral mode fall back to input
					dout_o = periph_dout_i;
					oe_o = PERIPH_OK & periph_oe_i;
				end
				default: begin
					oe_o = 1'b0;
				end
			endcase
		end
	end

	// open drain releases the pad on a high level but the enable status still shows output
	assign pin_oe_o = oe_o & ~(OD_OK & alt_drive_i & dout_o);
	assign fast_o = SLEW_OK & alt_drive_i;
endmodule : mio_pin_cell

// ==== rtl/mio_port_top.sv ====
// port A/B/C/D pin logic with drive-select and output-enable status registers
`timescale 1ns/1ns
module mio_port_top (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// control window
	input wire logic [7:0] win_addr_i,
	input wire logic win_rd_i,
	input wire logic win_wr_i,
	input wire logic [7:0] win_wdata_i,
	output logic [7:0] win_rdata_o,
	// pin modes
	input wire mio_pkg::mio_mode_t [7:0] pa_mode_i,
	input wire mio_pkg::mio_mode_t [7:0] pb_mode_i,
	input wire mio_pkg::mio_mode_t [7:0] pc_mode_i,
	input wire mio_pkg::mio_mode_t [7:0] pd_mode_i,
	// driver sources
	input wire mio_pkg::mio_pin_src_t pa_src_i,
	input wire mio_pkg::mio_pin_src_t pb_src_i,
	input wire mio_pkg::mio_pin_src_t pc_src_i,
	input wire mio_pkg::mio_pin_src_t pd_src_i,
	input wire logic [7:0] out_cells_bank_second_i,
	input wire logic [7:0] pb_alloc_sel_i,
	input wire logic external_select_one_i,
	input wire logic external_select_two_i,
	// dedicated functions
	input wire logic cfg_six_pin_i,
	input wire logic cfg_ready_busy_i,
	input wire logic cfg_standby_ind_i,
	input wire logic cfg_batt_in_i,
	input wire logic cfg_clkin_i,
	input wire logic cfg_csi_i,
	input wire logic program_progress_pin_i,
	input wire logic program_fault_pin_i,
	input wire logic prog_oe_i,
	input wire logic flash_ready_i,
	input wire logic sram_on_backup_i,
	// pins
	input wire logic [7:0] pa_pin_i,
	output logic [7:0] pa_pin_o,
	output logic [7:0] pa_pin_oe_o,
	input wire logic [7:0] pb_pin_i,
	output logic [7:0] pb_pin_o,
	output logic [7:0] pb_pin_oe_o,
	input wire logic [7:0] pc_pin_i,
	output logic [7:0] pc_pin_o,
	output logic [7:0] pc_pin_oe_o,
	input wire logic [7:0] pd_pin_i,
	output logic [7:0] pd_pin_o,
	output logic [7:0] pd_pin_oe_o,
	// drive type
	output logic [7:0] pa_fast_o,
	output logic [7:0] pb_fast_o,
	output logic [7:0] pc_fast_o,
	output logic [7:0] pd_fast_o,
	// to logic arrays and memories
	output logic [7:0] pa_in_o,
	output logic [7:0] pb_in_o,
	output logic [7:0] pc_in_o,
	output logic [7:0] pd_in_o,
	output logic common_clk_en_o,
	output logic mem_standby_o
);
	logic [7:0] drv_a_reg, drv_b_reg, drv_c_reg, drv_d_reg;
	logic [7:0] stat_a_reg, stat_b_reg, stat_c_reg, stat_d_reg;
	logic [7:0] a_dout, a_oe, a_poe, b_dout, b_oe, b_poe;
	logic [7:0] c_dout, c_oe, c_poe, d_dout, d_oe, d_poe;
	logic [7:0] b_cell, d_cell, c_ded_en, c_ded_dout, c_ded_oe, d_ded_en;
	logic [7:0] pc_fast, pd_fast;
	logic [21:0] sync_out;
	logic clk_prev_reg;
	logic [1:0] warm_reg;

	function automatic logic [7:0] read_mux(input logic [7:0] ofs, input logic [7:0] da, input logic [7:0] db,
		input logic [7:0] dc, input logic [7:0] dd, input logic [7:0] sa, input logic [7:0] sb,
		input logic [7:0] sc, input logic [7:0] sd);
		case (ofs)
			mio_pkg::DRV_A_OFS: read_mux = da;
			mio_pkg::DRV_B_OFS: read_mux = db;
			mio_pkg::DRV_C_OFS: read_mux = dc;
			mio_pkg::DRV_D_OFS: read_mux = dd;
			mio_pkg::OE_A_OFS: read_mux = sa;
			mio_pkg::OE_B_OFS: read_mux = sb;
			mio_pkg::OE_C_OFS: read_mux = sc;
			mio_pkg::OE_D_OFS: read_mux = sd;
			default: read_mux = 8'h00;
		endcase
	endfunction : read_mux

	// drive-select registers; status offsets take no write
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			drv_a_reg <= mio_pkg::REG_RESET;
			drv_b_reg <= mio_pkg::REG_RESET;
			drv_c_reg <= mio_pkg::REG_RESET;
			drv_d_reg <= mio_pkg::REG_RESET;
		end else if (win_wr_i) begin
			case (win_addr_i)
				mio_pkg::DRV_A_OFS: drv_a_reg <= win_wdata_i;
				mio_pkg::DRV_B_OFS: drv_b_reg <= win_wdata_i;
				mio_pkg::DRV_C_OFS: drv_c_reg <= win_wdata_i & mio_pkg::PC_PIN_MASK;
				mio_pkg::DRV_D_OFS: drv_d_reg <= win_wdata_i & mio_pkg::PD_PIN_MASK;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			win_rdata_o <= 8'h00;
		end else if (win_rd_i) begin
			win_rdata_o <= read_mux(win_addr_i, drv_a_reg, drv_b_reg, drv_c_reg, drv_d_reg,
				stat_a_reg, stat_b_reg, stat_c_reg, stat_d_reg);
		end
	end

	// port B output cells come from either bank through the allocator
	assign b_cell = (pb_alloc_sel_i & out_cells_bank_second_i) | (~pb_alloc_sel_i & pb_src_i.cell_dout);
	// port D logic outputs are the decode array selects, no output cell used
	always_comb begin
		d_cell = 8'h00;
		d_cell[mio_pkg::PD_CLK_BIT] = external_select_one_i;
		d_cell[mio_pkg::PD_CSI_BIT] = external_select_two_i;
	end

	// port C dedicated functions; programming status pins win over the others
	always_comb begin
		c_ded_en = 8'h00;
		c_ded_dout = 8'h00;
		c_ded_oe = 8'h00;
		d_ded_en = 8'h00;
		c_ded_en[mio_pkg::PC_BATT_BIT] = cfg_batt_in_i;
		if (cfg_six_pin_i) begin
			c_ded_en[mio_pkg::PC_RDY_BIT] = 1'b1;
			c_ded_en[mio_pkg::PC_STBY_BIT] = 1'b1;
			c_ded_dout[mio_pkg::PC_RDY_BIT] = program_progress_pin_i;
			c_ded_dout[mio_pkg::PC_STBY_BIT] = program_fault_pin_i;
			c_ded_oe[mio_pkg::PC_RDY_BIT] = prog_oe_i;
			c_ded_oe[mio_pkg::PC_STBY_BIT] = prog_oe_i;
		end else begin
			c_ded_en[mio_pkg::PC_RDY_BIT] = cfg_ready_busy_i;
			c_ded_dout[mio_pkg::PC_RDY_BIT] = flash_ready_i;
			c_ded_oe[mio_pkg::PC_RDY_BIT] = 1'b1;
			c_ded_en[mio_pkg::PC_STBY_BIT] = cfg_standby_ind_i;
			c_ded_dout[mio_pkg::PC_STBY_BIT] = sram_on_backup_i;
			c_ded_oe[mio_pkg::PC_STBY_BIT] = 1'b1;
		end
		// clock and select inputs keep the driver off
		d_ded_en[mio_pkg::PD_CLK_BIT] = cfg_clkin_i;
		d_ded_en[mio_pkg::PD_CSI_BIT] = cfg_csi_i;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_ab
			mio_pin_cell #(
				.OD_OK(mio_pkg::AB_OD_MASK[gi]), .SLEW_OK(mio_pkg::AB_SLEW_MASK[gi]),
				.PERIPH_OK(1'b1), .ADDR_OK(1'b1)
			) u_a (
				.mode_i(pa_mode_i[gi]), .mcu_dir_i(pa_src_i.mcu_dir[gi]), .mcu_dout_i(pa_src_i.mcu_dout[gi]),
				.cell_dout_i(pa_src_i.cell_dout[gi]), .cell_oe_i(pa_src_i.cell_oe[gi]),
				.addr_dout_i(pa_src_i.addr_dout[gi]), .periph_dout_i(pa_src_i.periph_dout[gi]),
				.periph_oe_i(pa_src_i.periph_oe[gi]), .alt_drive_i(drv_a_reg[gi]),
				.ded_en_i(1'b0), .ded_dout_i(1'b0), .ded_oe_i(1'b0),
				.dout_o(a_dout[gi]), .oe_o(a_oe[gi]), .pin_oe_o(a_poe[gi]), .fast_o(pa_fast_o[gi])
			);
			mio_pin_cell #(
				.OD_OK(mio_pkg::AB_OD_MASK[gi]), .SLEW_OK(mio_pkg::AB_SLEW_MASK[gi]),
				.PERIPH_OK(1'b0), .ADDR_OK(1'b1)
			) u_b (
				.mode_i(pb_mode_i[gi]), .mcu_dir_i(pb_src_i.mcu_dir[gi]), .mcu_dout_i(pb_src_i.mcu_dout[gi]),
				.cell_dout_i(b_cell[gi]), .cell_oe_i(pb_src_i.cell_oe[gi]), .addr_dout_i(pb_src_i.addr_dout[gi]),
				.periph_dout_i(1'b0), .periph_oe_i(1'b0), .alt_drive_i(drv_b_reg[gi]),
				.ded_en_i(1'b0), .ded_dout_i(1'b0), .ded_oe_i(1'b0),
				.dout_o(b_dout[gi]), .oe_o(b_oe[gi]), .pin_oe_o(b_poe[gi]), .fast_o(pb_fast_o[gi])
			);
			if (mio_pkg::PC_PIN_MASK[gi]) begin : g_c
				mio_pin_cell #(
					.OD_OK(1'b1), .SLEW_OK(1'b0), .PERIPH_OK(1'b0), .ADDR_OK(1'b0)
				) u_c (
					.mode_i(pc_mode_i[gi]), .mcu_dir_i(pc_src_i.mcu_dir[gi]), .mcu_dout_i(pc_src_i.mcu_dout[gi]),
					.cell_dout_i(pc_src_i.cell_dout[gi]), .cell_oe_i(pc_src_i.cell_oe[gi]),
					.addr_dout_i(1'b0), .periph_dout_i(1'b0), .periph_oe_i(1'b0), .alt_drive_i(drv_c_reg[gi]),
					.ded_en_i(c_ded_en[gi]), .ded_dout_i(c_ded_dout[gi]), .ded_oe_i(c_ded_oe[gi]),
					.dout_o(c_dout[gi]), .oe_o(c_oe[gi]), .pin_oe_o(c_poe[gi]), .fast_o(pc_fast[gi])
				);
			end else begin : g_c_scan
				// boundary-scan positions belong to the test port only
				assign c_dout[gi] = 1'b0;
				assign c_oe[gi] = 1'b0;
				assign c_poe[gi] = 1'b0;
				assign pc_fast[gi] = 1'b0;
			end
			if (mio_pkg::PD_PIN_MASK[gi]) begin : g_d
				mio_pin_cell #(
					.OD_OK(1'b0), .SLEW_OK(1'b1), .PERIPH_OK(1'b0), .ADDR_OK(1'b0)
				) u_d (
					.mode_i(pd_mode_i[gi]), .mcu_dir_i(pd_src_i.mcu_dir[gi]), .mcu_dout_i(pd_src_i.mcu_dout[gi]),
					.cell_dout_i(d_cell[gi]), .cell_oe_i(pd_src_i.cell_oe[gi]),
					.addr_dout_i(1'b0), .periph_dout_i(1'b0), .periph_oe_i(1'b0), .alt_drive_i(drv_d_reg[gi]),
					.ded_en_i(d_ded_en[gi]), .ded_dout_i(1'b0), .ded_oe_i(1'b0),
					.dout_o(d_dout[gi]), .oe_o(d_oe[gi]), .pin_oe_o(d_poe[gi]), .fast_o(pd_fast[gi])
				);
			end else begin : g_d_none
				assign d_dout[gi] = 1'b0;
				assign d_oe[gi] = 1'b0;
				assign d_poe[gi] = 1'b0;
				assign pd_fast[gi] = 1'b0;
			end
		end
	endgenerate

	assign pc_fast_o = pc_fast;
	assign pd_fast_o = pd_fast;

	// pin drivers sample the open-drain gated enable; status samples the mode enable ahead of that gate
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			{pa_pin_o, pb_pin_o, pc_pin_o, pd_pin_o} <= '0;
			{pa_pin_oe_o, pb_pin_oe_o, pc_pin_oe_o, pd_pin_oe_o} <= '0;
		end else begin
			{pa_pin_o, pb_pin_o, pc_pin_o, pd_pin_o} <= {a_dout, b_dout, c_dout, d_dout};
			{pa_pin_oe_o, pb_pin_oe_o, pc_pin_oe_o, pd_pin_oe_o} <= {a_poe, b_poe, c_poe, d_poe};
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			stat_a_reg <= mio_pkg::REG_RESET;
			stat_b_reg <= mio_pkg::REG_RESET;
			stat_c_reg <= mio_pkg::REG_RESET;
			stat_d_reg <= mio_pkg::REG_RESET;
		end else begin
			stat_a_reg <= a_oe;
			stat_b_reg <= b_oe;
			stat_c_reg <= c_oe & mio_pkg::PC_PIN_MASK;
			stat_d_reg <= d_oe & mio_pkg::PD_PIN_MASK;
		end
	end

	// pin inputs: A, B, used C pins, used D pins
	mio_sync #(.W(22)) u_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.async_i({pd_pin_i[2:1], pc_pin_i[7], pc_pin_i[4:2], pb_pin_i, pa_pin_i}),
		.sync_o(sync_out)
	);

	assign pa_in_o = sync_out[7:0];
	assign pb_in_o = sync_out[15:8];
	assign pc_in_o = {sync_out[19], 2'b00, sync_out[18:16], 2'b00};
	assign pd_in_o = {5'b00000, sync_out[21:20], 1'b0};

	// edge of the external clock becomes a one-cycle enable for the cells and power-down counter
	// the synchroniser shows zero for two edges after reset while a pulled-up pin idles high,
	// so the previous level is held high until the synchronised value is real: no false edge after reset
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			warm_reg <= 2'b00;
		end else begin
			warm_reg <= {warm_reg[0], 1'b1};
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			clk_prev_reg <= 1'b1;
		end else begin
			clk_prev_reg <= warm_reg[1] ? sync_out[20] : 1'b1;
		end
	end
	assign common_clk_en_o = cfg_clkin_i & sync_out[20] & ~clk_prev_reg;
	assign mem_standby_o = cfg_csi_i & sync_out[21];

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	chk_status_reset: assert property ($fell(rst_i) |-> (stat_a_reg | stat_b_reg | stat_c_reg | stat_d_reg) == 8'h00)
		else $error("status not zero after reset");
	chk_pb_status_pin: assert property (##1 (stat_b_reg[3:0] == pb_pin_oe_o[3:0]))
		else $error("port B status differs from driver enable");
	chk_pa_status_oe: assert property (win_wr_i && win_addr_i == mio_pkg::OE_A_OFS |=> stat_a_reg == $past(a_oe))
		else $error("status changed by write");
	chk_pc_scan_zero: assert property (stat_c_reg[6:5] == 2'b00 && stat_c_reg[1:0] == 2'b00)
		else $error("port C scan bits nonzero");
	chk_pd_unused_zero: assert property ((stat_d_reg & 8'hF9) == 8'h00)
		else $error("port D unused bits nonzero");
	chk_drive_write: assert property (win_wr_i && win_addr_i == mio_pkg::DRV_A_OFS |=> drv_a_reg == $past(win_wdata_i))
		else $error("drive select not written");
	chk_csi_standby: assert property ((cfg_csi_i && pd_pin_i[2]) [*3] |-> mem_standby_o)
		else $error("memories not in standby");
	chk_six_pin_own: assert property (cfg_six_pin_i ##1 cfg_six_pin_i |-> pc_pin_o[3] == $past(program_progress_pin_i))
		else $error("pin C3 not carrying programming status");
	chk_ready_busy: assert property (!cfg_six_pin_i && cfg_ready_busy_i |=> pc_pin_o[3] == $past(flash_ready_i))
		else $error("ready/busy not on pin C3");
	chk_clk_pulse: assert property (common_clk_en_o |-> cfg_clkin_i ##1 !common_clk_en_o)
		else $error("common clock enable not a single pulse");

endmodule : mio_port_top

// ==== verif/mio_pin_partner.sv ====
// external devices on one port: weak pull-up plus an optional outside driver
`timescale 1ns/1ns
module mio_pin_partner (
	// device side
	input wire logic [7:0] pin_o_i,
	input wire logic [7:0] pin_oe_i,
	// outside driver
	input wire logic [7:0] ext_en_i,
	input wire logic [7:0] ext_val_i,
	// resolved pad level
	output logic [7:0] pin_lvl_o
);
	// the pull-up lifts released and open-drain pads, so an undriven pad never shows a stale value
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			pin_lvl_o[k] = (pin_oe_i[k] ? pin_o_i[k] : 1'b1) & (ext_en_i[k] ? ext_val_i[k] : 1'b1);
		end
	end
endmodule : mio_pin_partner

// ==== verif/module_io_port_structure_tb.sv ====
// self-checking bench for the port logic against an integer reference model
`timescale 1ns/1ns
module module_io_port_structure_tb;
	localparam logic [7:0] OE_OFS [4] = '{mio_pkg::OE_A_OFS, mio_pkg::OE_B_OFS, mio_pkg::OE_C_OFS, mio_pkg::OE_D_OFS};
	localparam logic [7:0] DR_OFS [4] = '{mio_pkg::DRV_A_OFS, mio_pkg::DRV_B_OFS, mio_pkg::DRV_C_OFS, mio_pkg::DRV_D_OFS};
	localparam logic [7:0] PM [4] = '{8'hFF, 8'hFF, mio_pkg::PC_PIN_MASK, mio_pkg::PD_PIN_MASK};
	localparam logic [7:0] OD_M [4] = '{mio_pkg::AB_OD_MASK, mio_pkg::AB_OD_MASK, mio_pkg::PC_PIN_MASK, 8'h00};
	localparam logic [7:0] SL_M [4] = '{mio_pkg::AB_SLEW_MASK, mio_pkg::AB_SLEW_MASK, 8'h00, mio_pkg::PD_PIN_MASK};
	logic clk, rst, rd, wr, external_select_one, external_select_two, prog_p, prog_f, prog_oe, fl_rdy, sram_bk, clk_en, standby;
	logic [7:0] addr, wdata, rdata, bank2, sel, r, ep, pls;
	logic [5:0] cfg;
	mio_pkg::mio_mode_t [7:0] md [4];
	mio_pkg::mio_pin_src_t src [4];
	logic [7:0] pi [4], po [4], poe [4], fast [4], pin_in [4], ext_en [4], ext_val [4], drv [4];
	logic [63:0] rr;
	logic [15:0] me;
	int n_mismatch, compares;
	integer seed = 32'hFB595CFC;

	mio_port_top i_mio_port_top (
		.core_clk_i(clk), .rst_i(rst), .win_addr_i(addr), .win_rd_i(rd), .win_wr_i(wr),
		.win_wdata_i(wdata), .win_rdata_o(rdata),
		.pa_mode_i(md[0]), .pb_mode_i(md[1]), .pc_mode_i(md[2]), .pd_mode_i(md[3]),
		.pa_src_i(src[0]), .pb_src_i(src[1]), .pc_src_i(src[2]), .pd_src_i(src[3]),
		.out_cells_bank_second_i(bank2), .pb_alloc_sel_i(sel),
		.external_select_one_i(external_select_one), .external_select_two_i(external_select_two),
		.cfg_six_pin_i(cfg[0]), .cfg_ready_busy_i(cfg[1]), .cfg_standby_ind_i(cfg[2]),
		.cfg_batt_in_i(cfg[3]), .cfg_clkin_i(cfg[4]), .cfg_csi_i(cfg[5]),
		.program_progress_pin_i(prog_p), .program_fault_pin_i(prog_f), .prog_oe_i(prog_oe),
		.flash_ready_i(fl_rdy), .sram_on_backup_i(sram_bk),
		.pa_pin_i(pi[0]), .pa_pin_o(po[0]), .pa_pin_oe_o(poe[0]),
		.pb_pin_i(pi[1]), .pb_pin_o(po[1]), .pb_pin_oe_o(poe[1]),
		.pc_pin_i(pi[2]), .pc_pin_o(po[2]), .pc_pin_oe_o(poe[2]),
		.pd_pin_i(pi[3]), .pd_pin_o(po[3]), .pd_pin_oe_o(poe[3]),
		.pa_fast_o(fast[0]), .pb_fast_o(fast[1]), .pc_fast_o(fast[2]), .pd_fast_o(fast[3]),
		.pa_in_o(pin_in[0]), .pb_in_o(pin_in[1]), .pc_in_o(pin_in[2]), .pd_in_o(pin_in[3]),
		.common_clk_en_o(clk_en), .mem_standby_o(standby)
	);

	for (genvar p = 0; p < 4; p++) begin : g_far
		mio_pin_partner i_mio_pin_partner (.pin_o_i(po[p]), .pin_oe_i(poe[p]), .ext_en_i(ext_en[p]),
			.ext_val_i(ext_val[p]), .pin_lvl_o(pi[p]));
	end

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		d = rdata;
	endtask : rd_reg

	// the model keeps only the bits that the port really has
	task automatic set_drv(input int p, input logic [7:0] d);
		drv[p] = d & (OD_M[p] | SL_M[p]);
		wr_reg(DR_OFS[p], d);
	endtask : set_drv

	task automatic rnd();
		for (int p = 0; p < 4; p++) begin
			rr = {$random(seed), $random(seed)};
			src[p] = rr[55:0];
			for (int b = 0; b < 8; b++) md[p][b] = mio_pkg::mio_mode_t'(($random(seed) & 32'h7FFFFFFF) % 5);
			rr = {$random(seed), $random(seed)};
			ext_en[p] = rr[7:0];
			ext_val[p] = rr[15:8];
		end
		rr = {$random(seed), $random(seed)};
		{bank2, sel, external_select_one, external_select_two} = rr[17:0];
	endtask : rnd

	// returns combined enable and data of each pin, dedicated functions off
	function automatic logic [15:0] model(input int p);
		logic [7:0] oe, d, cd;
		int m;
		cd = p == 1 ? (sel & bank2 | ~sel & src[p].cell_dout) : src[p].cell_dout;
		if (p == 3)
			cd = {5'h00, external_select_two, external_select_one, 1'b0};
		for (int b = 0; b < 8; b++) begin
			m = int'(md[p][b]);
			oe[b] = m == 0 ? src[p].mcu_dir[b] : m == 1 ? src[p].cell_oe[b] : m == 3 ? p < 2 : m == 4 && p == 0 && src[p].periph_oe[b];
			d[b] = m == 0 ? src[p].mcu_dout[b] : m == 3 ? src[p].addr_dout[b] : m == 4 ? src[p].periph_dout[b] : cd[b];
		end
		return {oe & PM[p], d};
	endfunction : model

	task automatic conclude();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude

	initial begin
		#300000;
		n_mismatch++;
		conclude();
	end

	initial begin
		{rst, rd, wr, addr, wdata, cfg, prog_p, prog_f, prog_oe, fl_rdy, sram_bk} = '0;
		rst = 1'b1;
		rnd();
		for (int p = 0; p < 4; p++) begin
			drv[p] = 8'h00;
			for (int b = 0; b < 8; b++) md[p][b] = mio_pkg::MIO_MODE_LOGIC_IN;
		end
		cyc(6);
		for (int p = 0; p < 4; p++) chk("pin_oe_rst", poe[p], 8'h00);
		rst = 1'b0;
		for (int p = 0; p < 4; p++) begin
			rd_reg(OE_OFS[p], r);
			chk("status_rst", r, 8'h00);
			rd_reg(DR_OFS[p], r);
			chk("drive_rst", r, 8'h00);
		end
		repeat (40) begin
			rnd();
			for (int p = 0; p < 4; p++) begin
				rr = {$random(seed), $random(seed)};
				set_drv(p, rr[7:0]);
			end
			cyc(4);
			for (int p = 0; p < 4; p++) begin
				me = model(p);
				ep = me[15:8] & ~(me[7:0] & drv[p] & OD_M[p]);
				chk("pin_oe", poe[p], ep);
				chk("pin_o", po[p] & ep, me[7:0] & ep);
				chk("fast", fast[p], drv[p] & SL_M[p]);
				chk("pin_in", pin_in[p], pi[p] & PM[p]);
				wr_reg(OE_OFS[p], rr[15:8]);
				rd_reg(OE_OFS[p], r);
				chk("status", r, me[15:8]);
				rd_reg(DR_OFS[p], r);
				chk("drive", r, drv[p]);
			end
		end
		rd_reg(8'h40, r);
		chk("unmapped", r, 8'h00);
		for (int p = 0; p < 4; p++) begin
			for (int b = 0; b < 8; b++) md[p][b] = mio_pkg::MIO_MODE_MCU_IO;
			src[p].mcu_dir = 8'hFF;
			ext_en[p] = 8'h00;
			set_drv(p, 8'h00);
		end
		// ready/busy, standby indicator and battery input together
		cfg = 6'b001110;
		for (int v = 0; v < 2; v++) begin
			{fl_rdy, sram_bk, prog_p, prog_f, prog_oe} = {v[0], v[0], v[0], ~v[0], 1'b1};
			cfg[0] = 1'b0;
			cyc(3);
			chk("pc_oe", poe[2], 8'h98);
			chk("pc_ind", {6'h00, po[2][4:3]}, {6'h00, v[0], v[0]});
			cfg[0] = 1'b1;
			cyc(3);
			chk("pc_prog", {6'h00, po[2][4:3]}, {6'h00, ~v[0], v[0]});
		end
		cfg = 6'b110000;
		ext_en[3] = 8'h06;
		ext_val[3] = 8'h00;
		cyc(4);
		chk("pd_oe", poe[3], 8'h00);
		chk("standby", {7'h00, standby}, 8'h00);
		ext_val[3] = 8'h06;
		pls = 8'h00;
		repeat (6) begin
			cyc(1);
			pls = pls + {7'h00, clk_en};
		end
		chk("clk_pulses", pls, 8'h01);
		chk("standby", {7'h00, standby}, 8'h01);
		chk("pd_in", pin_in[3], 8'h06);
		ext_val[3] = 8'h00;
		cyc(4);
		chk("standby", {7'h00, standby}, 8'h00);
		// clock input on a pulled-up pin held through a reset must give no pulse after release
		cfg = 6'b010000;
		ext_en[3] = 8'h00;
		wr_reg(DR_OFS[0], 8'hA5);
		rst = 1'b1;
		cyc(2);
		chk("pa_oe_rst", poe[0], 8'h00);
		rst = 1'b0;
		pls = 8'h00;
		repeat (4) begin
			cyc(1);
			pls = pls + {7'h00, clk_en};
		end
		chk("clk_pulses_rst", pls, 8'h00);
		rd_reg(DR_OFS[0], r);
		chk("drive_rst", r, 8'h00);
		conclude();
	end
endmodule : module_io_port_structure_tb
